// [rtl/sbc_pkg.sv]
package sbc_pkg;
	// ==========
	// control word field positions
	localparam int CW_HS1 = 1;
	localparam int CW_HS2 = 2;
	localparam int CW_HS3 = 3;
	localparam int CW_LS1 = 5;
	localparam int CW_LS2 = 6;
	localparam int CW_MODE_LO = 9;
	localparam int CW_MODE_HI = 10;
	localparam int CW_PWM_EN = 11;
	localparam int CW_CYC_LO = 12;
	localparam int CW_CYC_HI = 13;
	localparam logic [15:0] CW_RESET = 16'h0000;
	// ==========
	// mode codes on mode_bit_high, mode_bit_low
	localparam logic [1:0] MODE_NORMAL = 2'h3;
	localparam logic [1:0] MODE_CYCLIC = 2'h2;
	localparam logic [1:0] MODE_RXONLY = 2'h1;
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	// ==========
	// cyclic wake period in 512us ticks
	localparam logic [1:0] CYC_NONE = 2'h3;
	localparam logic [8:0] CYC_P0 = 9'd94;
	localparam logic [8:0] CYC_P1 = 9'd188;
	localparam logic [8:0] CYC_P2 = 9'd376;
	// ==========
	// timing
	localparam int MCLK_NS = 100;
	localparam int TICK_US = 512;
	localparam int TICK_CYC = (TICK_US * 1000) / MCLK_NS;
	localparam int LOW_MS = 64;
	localparam logic [8:0] LOW_TICKS =
		9'((LOW_MS * 1000 + TICK_US - 1) / TICK_US);
	localparam int DOM_US = 1000;
	localparam int DOM_CYC = (DOM_US * 1000) / MCLK_NS;
	localparam int FILT_ON_US = 40;
	localparam int FILT_OFF_US = 40;
	localparam logic [11:0] FILT_ON_CYC =
		12'((FILT_ON_US * 1000 + MCLK_NS - 1) / MCLK_NS);
	localparam logic [11:0] FILT_OFF_CYC =
		12'((FILT_OFF_US * 1000 + MCLK_NS - 1) / MCLK_NS);
	// ==========
	// operating states, gray along the usual path
	typedef enum logic [2:0] {
		ST_STBY = 3'h0,
		ST_RXONLY = 3'h1,
		ST_NORMAL = 3'h3,
		ST_CYC_ON = 3'h2,
		ST_CYC_OFF = 3'h6
	} sbc_state_t;
endpackage

// [rtl/sbc_mode_ctrl.sv]
// Overview of operation
// - power-up or watchdog reset enters battery standby
// - standby: transceiver off, bus wake drives rxd low
// - wake pin acts only in cyclic off state
// - undervoltage forces standby, or power down
// - each cyclic on entry starts long window
// - cyclic on: only high side switch 3 on
// - no trigger in long window gives watchdog reset
// - only pwm trigger moves cyclic on to off
// - cyclic off: switches, watchdog and spi off
// - cyclic off counts 512us ticks, then on
// - bits 13:12 pick 94, 188, 376, none
// - timer, bus wake or wake edge leave off
// - switch 1 follows bit 1, pwm gated
// - reset forces all selected switches off
// - function enables follow the mode table
// - low termination to vcc or battery per mode
// - filtered entry and exit of single wire
// - failed line loses termination, driver, receiver
// - failure flags held until next can word
// - flag bits 13 to 9 map failure groups
// - bit 0 on data out, cleared by csn rise
// - long dominant txd disables both drivers
// - bits 10:9 select the operating mode
// - receive only never drives the bus
`timescale 1ns/1ps
module sbc_mode_ctrl #(
	parameter int TICK_CYC_P = sbc_pkg::TICK_CYC,
	parameter int DOM_CYC_P = sbc_pkg::DOM_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// reset sources
	input wire logic por_evt,
	input wire logic wd_expire,
	input wire logic uv_reset,
	input wire logic supply_lost,
	// control word and host pins
	input wire logic [15:0] ctrl_word,
	input wire logic ctrl_load,
	input wire logic wd_trig_ok,
	input wire logic pwm_pin,
	input wire logic wake_pin,
	input wire logic csn,
	// can side
	input wire logic can_wake,
	input wire logic txd,
	input wire logic rx_diff,
	input wire logic rx_h_se,
	input wire logic rx_l_se,
	input wire logic line_h_fault,
	input wire logic line_l_fault,
	input wire logic [5:0] fail_grp,
	input wire logic can_word_start,
	// mode and resets out
	output sbc_pkg::sbc_state_t op_state,
	output logic wd_reset,
	output logic power_down,
	output logic long_window,
	output logic wd_spi_en,
	// transceiver
	output logic rxd,
	output logic rx_en,
	output logic tx_h_en,
	output logic tx_l_en,
	output logic low_line_termination,
	output logic low_term_en,
	output logic high_term_en,
	output logic [1:0] single_wire,
	// switches
	output logic high_side_switch_1,
	output logic high_side_switch_2,
	output logic high_side_switch_3,
	output logic low_side_switch_1,
	output logic low_side_switch_2,
	// diagnosis
	output logic [5:0] diag_fail,
	output logic bus_fail,
	output logic so_bit,
	output logic so_oe
);
	import sbc_pkg::*;

	// ==========
	// decode helpers
	function automatic sbc_state_t mode_state(input logic [1:0] m);
		case (m)
			MODE_NORMAL: mode_state = ST_NORMAL;
			MODE_CYCLIC: mode_state = ST_CYC_ON;
			MODE_RXONLY: mode_state = ST_RXONLY;
			default: mode_state = ST_STBY;
		endcase
	endfunction

	sbc_state_t st;
	sbc_state_t next_st;
	logic [15:0] ctrl;
	logic [12:0] div;
	logic [8:0] lw_cnt;
	logic [8:0] cyc_cnt;
	logic lw_act;
	logic wd_gen;
	logic wk_q;
	logic pwm_q;
	logic csn_q;
	logic wake_seen;
	logic [13:0] dom_cnt;
	logic dom_to;
	logic [1:0] line_off;

	wire tick = (div == 13'(TICK_CYC_P - 1));
	wire wd_any = wd_gen | wd_expire;
	wire sys_rst = por_evt | wd_any | uv_reset;
	wire wake_rise = wake_pin & ~wk_q;
	wire pwm_rise = pwm_pin & ~pwm_q;
	wire csn_rise = csn & ~csn_q;
	wire [1:0] req_mode = {ctrl_word[CW_MODE_HI], ctrl_word[CW_MODE_LO]};
	wire [1:0] cyc_sel = {ctrl[CW_CYC_HI], ctrl[CW_CYC_LO]};
	wire [8:0] cyc_per = (cyc_sel == 2'h0) ? CYC_P0 :
		(cyc_sel == 2'h1) ? CYC_P1 : CYC_P2;
	wire cyc_exp = tick & (cyc_sel != CYC_NONE) &
		(cyc_cnt == cyc_per - 9'h001);
	wire spi_on = (st != ST_CYC_OFF);
	wire sw_on = (st == ST_NORMAL) | (st == ST_RXONLY) | (st == ST_STBY);
	wire tx_on = (st == ST_NORMAL);
	wire rx_on = (st == ST_NORMAL) | (st == ST_RXONLY);
	wire on_entry = (st != ST_CYC_ON) & (next_st == ST_CYC_ON);
	wire rx_mux = line_off[0] ? rx_l_se :
		line_off[1] ? rx_h_se : rx_diff;
	wire hs1_src = ctrl[CW_PWM_EN] ? pwm_pin : 1'b1;

	// ==========
	// mode sequencing
	always_comb begin
		next_st = st;
		case (st)
			ST_CYC_ON: begin
				if (pwm_rise) begin
					next_st = ST_CYC_OFF;
				end else if (ctrl_load && req_mode != MODE_CYCLIC) begin
					next_st = mode_state(req_mode);
				end
			end
			ST_CYC_OFF: begin
				if (cyc_exp || can_wake || wake_rise) begin
					next_st = ST_CYC_ON;
				end
			end
			ST_NORMAL, ST_RXONLY, ST_STBY: begin
				if (ctrl_load) begin
					next_st = mode_state(req_mode);
				end
			end
			default: next_st = ST_STBY;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || sys_rst) begin
			st <= ST_STBY;
		end else begin
			st <= next_st;
		end
	end

	// control word, cleared by any reset
	always_ff @(posedge mclk) begin
		if (!rst_n || sys_rst) begin
			ctrl <= CW_RESET;
		end else if (ctrl_load && spi_on) begin
			ctrl <= ctrl_word;
		end
	end

	// ==========
	// oscillator tick and edge history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div <= 13'h0000;
			wk_q <= 1'b0;
			pwm_q <= 1'b0;
			csn_q <= 1'b1;
		end else begin
			div <= tick ? 13'h0000 : div + 13'h0001;
			wk_q <= wake_pin;
			pwm_q <= pwm_pin;
			csn_q <= csn;
		end
	end

	// ==========
	// long open window and cyclic timer
	always_ff @(posedge mclk) begin
		if (!rst_n || sys_rst) begin
			lw_act <= 1'b0;
			lw_cnt <= 9'h000;
			wd_gen <= 1'b0;
		end else if (on_entry) begin
			lw_act <= 1'b1;
			lw_cnt <= 9'h000;
			wd_gen <= 1'b0;
		end else if (st != ST_CYC_ON || wd_trig_ok || pwm_rise) begin
			lw_act <= 1'b0;
			wd_gen <= 1'b0;
		end else begin
			if (lw_act && tick) begin
				lw_cnt <= lw_cnt + 9'h001;
			end
			wd_gen <= lw_act & tick & (lw_cnt == LOW_TICKS - 9'h001);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || st != ST_CYC_OFF) begin
			cyc_cnt <= 9'h000;
		end else if (tick) begin
			cyc_cnt <= cyc_cnt + 9'h001;
		end
	end

	// ==========
	// bus wake report and dominant timeout
	always_ff @(posedge mclk) begin
		if (!rst_n || rx_on) begin
			wake_seen <= 1'b0;
		end else if (can_wake) begin
			wake_seen <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || txd) begin
			dom_cnt <= 14'h0000;
			dom_to <= 1'b0;
		end else if (dom_cnt == 14'(DOM_CYC_P - 1)) begin
			dom_to <= 1'b1;
		end else begin
			dom_cnt <= dom_cnt + 14'h0001;
		end
	end

	// ==========
	// single wire filters, 0 = high line, 1 = low line
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			logic [11:0] fcnt;
			wire fault = (gi == 0) ? line_h_fault : line_l_fault;
			wire [11:0] lim = line_off[gi] ? FILT_OFF_CYC : FILT_ON_CYC;
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					fcnt <= 12'h000;
					line_off[gi] <= 1'b0;
				end else if (fault == line_off[gi]) begin
					fcnt <= 12'h000;
				end else if (fcnt == lim - 12'h001) begin
					fcnt <= 12'h000;
					line_off[gi] <= fault;
				end else begin
					fcnt <= fcnt + 12'h001;
				end
			end
		end
	endgenerate

	// ==========
	// diagnosis flags
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			diag_fail <= 6'h00;
			bus_fail <= 1'b0;
			so_bit <= 1'b0;
		end else begin
			diag_fail <= fail_grp |
				(can_word_start ? 6'h00 : diag_fail);
			bus_fail <= (|fail_grp) | (csn_rise ? 1'b0 : bus_fail);
			so_bit <= (|fail_grp) | (csn_rise ? 1'b0 : bus_fail);
		end
	end
	assign so_oe = ~csn;

	// ==========
	// registered outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxd <= 1'b1;
			rx_en <= 1'b0;
			tx_h_en <= 1'b0;
			tx_l_en <= 1'b0;
			low_line_termination <= 1'b0;
			low_term_en <= 1'b1;
			high_term_en <= 1'b1;
			single_wire <= 2'h0;
			wd_spi_en <= 1'b1;
			wd_reset <= 1'b0;
			power_down <= 1'b0;
			long_window <= 1'b0;
		end else begin
			rxd <= rx_on ? rx_mux : ~(wake_seen | can_wake);
			rx_en <= rx_on;
			tx_h_en <= tx_on & ~dom_to & ~line_off[0];
			tx_l_en <= tx_on & ~dom_to & ~line_off[1];
			low_line_termination <= rx_on;
			low_term_en <= ~line_off[1];
			high_term_en <= ~line_off[0];
			single_wire <= line_off;
			wd_spi_en <= spi_on;
			wd_reset <= wd_any;
			power_down <= supply_lost;
			long_window <= lw_act;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || sys_rst) begin
			high_side_switch_1 <= 1'b0;
			high_side_switch_2 <= 1'b0;
			high_side_switch_3 <= 1'b0;
			low_side_switch_1 <= 1'b0;
			low_side_switch_2 <= 1'b0;
		end else begin
			high_side_switch_1 <= sw_on & ctrl[CW_HS1] & hs1_src;
			high_side_switch_2 <= sw_on & ctrl[CW_HS2];
			high_side_switch_3 <= sw_on ? ctrl[CW_HS3] :
				(st == ST_CYC_ON);
			low_side_switch_1 <= sw_on & ctrl[CW_LS1];
			low_side_switch_2 <= sw_on & ctrl[CW_LS2];
		end
	end
	assign op_state = st;

	// ==========
	// checks
	property p_rst_stby;
		@(posedge mclk) disable iff (!rst_n) sys_rst |=> st == ST_STBY;
	endproperty
	a_rst_stby: assert property (p_rst_stby) else $error("no standby");
	property p_stby_off;
		@(posedge mclk) disable iff (!rst_n)
		st == ST_STBY |=> !rx_en && !tx_h_en && !tx_l_en;
	endproperty
	a_stby_off: assert property (p_stby_off) else $error("xcvr on");
	property p_stby_hold;
		@(posedge mclk) disable iff (!rst_n)
		st == ST_STBY && !ctrl_load |=> st == ST_STBY;
	endproperty
	a_stby_hold: assert property (p_stby_hold) else $error("left stby");
	property p_lw;
		@(posedge mclk) disable iff (!rst_n)
		st != ST_CYC_ON ##1 st == ST_CYC_ON |=> lw_act || wd_trig_ok;
	endproperty
	a_lw: assert property (p_lw) else $error("no long window");
	property p_hs3;
		@(posedge mclk) disable iff (!rst_n)
		st == ST_CYC_ON && !sys_rst |=> high_side_switch_3 &&
			!high_side_switch_1 && !low_side_switch_1;
	endproperty
	a_hs3: assert property (p_hs3) else $error("cyclic switches");
	property p_off_pwm;
		@(posedge mclk) disable iff (!rst_n)
		st == ST_CYC_ON ##1 st == ST_CYC_OFF |-> $past(pwm_rise);
	endproperty
	a_off_pwm: assert property (p_off_pwm) else $error("bad off entry");
	property p_off_spi;
		@(posedge mclk) disable iff (!rst_n)
		st == ST_CYC_OFF |=> !wd_spi_en && !high_side_switch_3;
	endproperty
	a_off_spi: assert property (p_off_spi) else $error("spi on");
	property p_diag;
		@(posedge mclk) disable iff (!rst_n)
		!can_word_start |=>
			(diag_fail & $past(diag_fail)) == $past(diag_fail);
	endproperty
	a_diag: assert property (p_diag) else $error("flag lost");
	property p_bit0;
		@(posedge mclk) disable iff (!rst_n)
		csn_rise && fail_grp == 6'h00 |=> !bus_fail;
	endproperty
	a_bit0: assert property (p_bit0) else $error("bit0 kept");
	property p_dom;
		@(posedge mclk) disable iff (!rst_n)
		dom_to |=> !tx_h_en && !tx_l_en;
	endproperty
	a_dom: assert property (p_dom) else $error("driver on");
endmodule

// [verif/sbc_host.sv]
`timescale 1ns/1ps
// ==========
// host side: control word, watchdog trigger, pwm, chip select, txd
module sbc_host (
	// clock
	input wire logic mclk,
	// host pins
	output logic [15:0] ctrl_word,
	output logic ctrl_load,
	output logic wd_trig_ok,
	output logic pwm_pin,
	output logic csn,
	output logic txd
);
	import sbc_pkg::*;
	initial begin
		ctrl_word = CW_RESET;
		ctrl_load = 1'b0;
		wd_trig_ok = 1'b0;
		pwm_pin = 1'b0;
		csn = 1'b1;
		txd = 1'b1;
	end
	// mode in bits 10:9 of the word
	task automatic load(input logic [15:0] w);
		@(negedge mclk);
		ctrl_word = w;
		ctrl_load = 1'b1;
		@(negedge mclk);
		ctrl_load = 1'b0;
	endtask
	// valid trigger inside the long window
	task automatic trig();
		@(negedge mclk);
		wd_trig_ok = 1'b1;
		@(negedge mclk);
		wd_trig_ok = 1'b0;
	endtask
	// rising edge is the failsafe trigger
	task automatic pwm(input logic v);
		@(negedge mclk);
		pwm_pin = v;
	endtask
	task automatic sel(input logic v);
		@(negedge mclk);
		csn = v;
	endtask
	task automatic drive_txd(input logic v);
		@(negedge mclk);
		txd = v;
	endtask
endmodule

// [verif/sbc_mode_ctrl_tb.sv]
`timescale 1ns/1ps
module sbc_mode_ctrl_tb;
	import sbc_pkg::*;
	localparam int TK = 8;
	localparam int DOM = 20;
	logic mclk, rst_n, supply_lost, wake_pin, can_wake, can_word_start;
	logic [2:0] rsrc;
	logic [5:0] fail_grp, diag_fail;
	logic [15:0] ctrl_word;
	logic ctrl_load, wd_trig_ok, pwm_pin, csn, txd;
	sbc_state_t op_state;
	logic wd_reset, power_down, long_window, wd_spi_en, rxd, rx_en;
	logic tx_h_en, tx_l_en, llt, hs1, hs3, ls1, bus_fail, so_bit, so_oe;
	logic hs2, ls2, lte, hte, rx_diff, rx_h, rx_l, h_fault, l_fault;
	logic [1:0] single_wire;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	sbc_host host (.mclk(mclk), .ctrl_word(ctrl_word),
		.ctrl_load(ctrl_load), .wd_trig_ok(wd_trig_ok),
		.pwm_pin(pwm_pin), .csn(csn), .txd(txd));
	sbc_mode_ctrl #(.TICK_CYC_P(TK), .DOM_CYC_P(DOM)) uut (
		.mclk(mclk), .rst_n(rst_n), .por_evt(rsrc[0]),
		.wd_expire(rsrc[1]), .uv_reset(rsrc[2]),
		.supply_lost(supply_lost), .ctrl_word(ctrl_word),
		.ctrl_load(ctrl_load), .wd_trig_ok(wd_trig_ok),
		.pwm_pin(pwm_pin), .wake_pin(wake_pin), .csn(csn),
		.can_wake(can_wake), .txd(txd), .rx_diff(rx_diff),
		.rx_h_se(rx_h), .rx_l_se(rx_l), .line_h_fault(h_fault),
		.line_l_fault(l_fault), .fail_grp(fail_grp),
		.can_word_start(can_word_start), .op_state(op_state),
		.wd_reset(wd_reset), .power_down(power_down),
		.long_window(long_window), .wd_spi_en(wd_spi_en), .rxd(rxd),
		.rx_en(rx_en), .tx_h_en(tx_h_en), .tx_l_en(tx_l_en),
		.low_line_termination(llt), .low_term_en(lte),
		.high_term_en(hte), .single_wire(single_wire),
		.high_side_switch_1(hs1), .high_side_switch_2(hs2),
		.high_side_switch_3(hs3), .low_side_switch_1(ls1),
		.low_side_switch_2(ls2),
		.diag_fail(diag_fail), .bus_fail(bus_fail), .so_bit(so_bit),
		.so_oe(so_oe));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// switches 1,2,3 and low 1,2 all requested
	function automatic logic [15:0] word(input logic [1:0] m,
		input logic [1:0] p, input logic pw);
		return {2'h0, p, pw, m, 9'h06e};
	endfunction
	task automatic t_modes();
		logic [1:0] m;
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? MODE_NORMAL : (i == 1) ? MODE_RXONLY : MODE_STANDBY;
			host.load(word(m, 2'h0, 1'b0));
			step(3);
			check("tx", tx_h_en, m == MODE_NORMAL);
			check("rx", rx_en, m != MODE_STANDBY);
			check("term", llt, m != MODE_STANDBY);
			check("hs1", hs1, 1'b1);
			check("ls1", ls1, 1'b1);
			check("hs2", hs2, 1'b1);
			check("ls2", ls2, 1'b1);
		end
		host.load(word(MODE_NORMAL, 2'h0, 1'b1));
		step(3);
		check("hs1 pwm lo", hs1, 1'b0);
		host.pwm(1'b1);
		step(3);
		check("hs1 pwm hi", hs1, 1'b1);
		host.pwm(1'b0);
	endtask
	task automatic t_resets();
		for (int i = 0; i < 3; i++) begin
			host.load(word(MODE_NORMAL, 2'h0, 1'b0));
			step(3);
			rsrc = 3'(1 << i);
			step(1);
			rsrc = 3'h0;
			step(3);
			check("state rst", op_state, ST_STBY);
			check("hs1 rst", hs1, 1'b0);
			check("ls1 rst", ls1, 1'b0);
			wake_pin = 1'b1;
			step(3);
			wake_pin = 1'b0;
			check("wake stby", op_state, ST_STBY);
			can_wake = 1'b1;
			step(1);
			can_wake = 1'b0;
			step(3);
			check("rxd wake", rxd, 1'b0);
		end
		supply_lost = 1'b1;
		step(3);
		check("pdown", power_down, 1'b1);
		supply_lost = 1'b0;
	endtask
	// enter cyclic on, pwm to off, wait out the period
	task automatic t_cyc(input logic [1:0] p, input int n);
		host.load(word(MODE_NORMAL, 2'h0, 1'b0));
		host.load(word(MODE_CYCLIC, p, 1'b0));
		step(3);
		check("cyc on", op_state, ST_CYC_ON);
		check("lwin", long_window, 1'b1);
		check("hs3 on", hs3, 1'b1);
		check("hs1 on", hs1, 1'b0);
		check("rx on", rx_en, 1'b0);
		check("term cyc", llt, 1'b0);
		host.trig();
		step(2);
		check("lwin trig", long_window, 1'b0);
		host.pwm(1'b1);
		host.pwm(1'b0);
		step(3);
		check("cyc off", op_state, ST_CYC_OFF);
		check("hs3 off", hs3, 1'b0);
		check("wd spi", wd_spi_en, 1'b0);
		step(n * TK - 20);
		check("still off", op_state, ST_CYC_OFF);
		step(40);
		check("timer on", op_state, (p == CYC_NONE) ? ST_CYC_OFF : ST_CYC_ON);
	endtask
	task automatic t_wake();
		t_cyc(CYC_NONE, 430);
		wake_pin = 1'b1;
		step(3);
		wake_pin = 1'b0;
		check("wake pin", op_state, ST_CYC_ON);
		host.pwm(1'b1);
		host.pwm(1'b0);
		step(3);
		can_wake = 1'b1;
		step(1);
		can_wake = 1'b0;
		step(3);
		check("can wake", op_state, ST_CYC_ON);
		check("can rxd", rxd, 1'b0);
		for (int i = 0; i < 1200 && wd_reset !== 1'b1; i++) step(1);
		check("wd reset", wd_reset, 1'b1);
		step(3);
		check("wd stby", op_state, ST_STBY);
		check("hs3 wd", hs3, 1'b0);
	endtask
	task automatic t_diag();
		fail_grp = 6'h15;
		step(2);
		fail_grp = 6'h00;
		step(3);
		check("diag held", diag_fail, 6'h15);
		can_word_start = 1'b1;
		step(1);
		can_word_start = 1'b0;
		step(2);
		check("diag clr", diag_fail, 6'h00);
		host.sel(1'b0);
		step(2);
		check("so oe", so_oe, 1'b1);
		check("so bit", so_bit, 1'b1);
		host.sel(1'b1);
		step(3);
		check("bus fail", bus_fail, 1'b0);
		host.load(word(MODE_NORMAL, 2'h0, 1'b0));
		host.drive_txd(1'b0);
		step(5);
		check("tx dom", tx_h_en, 1'b1);
		step(DOM + 10);
		check("tx h to", tx_h_en, 1'b0);
		check("tx l to", tx_l_en, 1'b0);
		host.drive_txd(1'b1);
	endtask
	// line faults: filtered single wire entry and exit, mux, drivers
	task automatic t_line();
		rx_diff = 1'b0;
		rx_h = 1'b1;
		rx_l = 1'b1;
		step(3);
		check("rxd diff", rxd, 1'b0);
		check("hte ok", hte, 1'b1);
		h_fault = 1'b1;
		step(300);
		check("sw early", single_wire, 2'h0);
		step(110);
		check("sw h", single_wire, 2'h1);
		check("hte off", hte, 1'b0);
		check("lte on", lte, 1'b1);
		check("txh off", tx_h_en, 1'b0);
		check("txl on", tx_l_en, 1'b1);
		check("rxd l", rxd, 1'b1);
		rx_l = 1'b0;
		step(2);
		check("rxd l lo", rxd, 1'b0);
		h_fault = 1'b0;
		step(300);
		check("sw hold", single_wire, 2'h1);
		step(110);
		check("sw back", single_wire, 2'h0);
		check("rxd back", rxd, 1'b0);
		l_fault = 1'b1;
		rx_h = 1'b0;
		rx_l = 1'b1;
		step(410);
		check("sw l", single_wire, 2'h2);
		check("lte off", lte, 1'b0);
		check("txl off", tx_l_en, 1'b0);
		check("rxd h", rxd, 1'b0);
		l_fault = 1'b0;
		step(410);
		check("sw clr", single_wire, 2'h0);
	endtask
	initial begin
		rst_n = 1'b0;
		rsrc = 3'h0;
		supply_lost = 1'b0;
		wake_pin = 1'b0;
		can_wake = 1'b0;
		can_word_start = 1'b0;
		fail_grp = 6'h00;
		rx_diff = 1'b1;
		rx_h = 1'b1;
		rx_l = 1'b1;
		h_fault = 1'b0;
		l_fault = 1'b0;
		step(20);
		rst_n = 1'b1;
		step(2);
		check("rst state", op_state, ST_STBY);
		check("rst rxd", rxd, 1'b1);
		t_modes();
		t_resets();
		t_cyc(2'h0, 94);
		t_cyc(2'h1, 188);
		t_cyc(2'h2, 376);
		t_wake();
		t_diag();
		t_line();
		conclude();
	end
endmodule
